// ==== rtl/brt_pkg.sv ====
// Shared constants, types and helpers for banked trace capture.
// Assumes a single 10 MHz bus clock shared by both ends.
`default_nettype none

package brt_pkg;

	// ------------------------------------------------------------------
	// Widths and limits
	// ------------------------------------------------------------------
	localparam int ADDR_W     = 16;           // Normal 64K bus address
	localparam int BANK_W     = 4;            // Bank field, sixteen banks
	localparam int REC_W      = BANK_W + ADDR_W; // Bank above the address
	localparam int MAX_BANKS  = 16;           // Largest bank count traced
	localparam int MAX_32K_RSV = 15;          // 512K board, 32K reserved
	localparam int MAX_16K_RSV = 13;          // 256K board, 48K reserved
	localparam int CNT_W      = 32;           // Execution cycle counter
	localparam int FIFO_DEPTH = 16;           // Trace record buffer depth
	localparam int PROBE_BANK_LSB = 0;        // Probe bit for bank bit 2

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_HZ         = 10_000_000; // Bus clock rate
	localparam int RESET_HOLD_MS  = 200;        // Reset hold, 1/5 second
	localparam int RESET_HOLD_CYC = (CLK_HZ / 1000) * RESET_HOLD_MS;
	localparam int PROT_WIN_CYC   = 64;         // Write-once window

	// ------------------------------------------------------------------
	// Extended address line of bank bit 0 per bank size
	// ------------------------------------------------------------------
	localparam int XA_LSB_8K  = 13;
	localparam int XA_LSB_16K = 14;
	localparam int XA_LSB_32K = 15;           // Line 14 is not a bank bit

	// Bank size selection
	typedef enum logic [2:0] {
		BS_8K  = 3'h1,
		BS_16K = 3'h2,
		BS_32K = 3'h4
	} brt_bsize_e;

	// Bank count the emulation board can serve
	function automatic logic [4:0] brt_max_banks(input logic b512,
		input logic nb_mapped, input logic [2:0] bsize);
		brt_max_banks = 5'(MAX_BANKS);
		if (nb_mapped && b512 && bsize == BS_32K) begin
			brt_max_banks = 5'(MAX_32K_RSV);
		end
		if (nb_mapped && !b512 && bsize == BS_16K) begin
			brt_max_banks = 5'(MAX_16K_RSV);
		end
	endfunction

endpackage

`default_nettype wire

// ==== rtl/brt_link_if.sv ====
// Link between the emulator trace end and the target bus end.
// Assumes both ends run on the same clock; no clocking block here.
`default_nettype none

interface brt_link_if;
	logic                        cyc_valid;             // Bus cycle offered
	logic [brt_pkg::ADDR_W-1:0]  cyc_addr;              // Its 16-bit address
	logic                        bank_sel_bit0;         // Bank bit 0
	logic                        bank_sel_bit1;         // Bank bit 1
	logic [3:0]                  aux_trace_inputs_high; // General probes
	logic                        cyc_hold;              // Emulator stalls bus
	logic                        tgt_reset_n;           // Target reset, low
	logic                        emul_run;              // Emulation mode

	// Emulator end
	modport emu (
		input  cyc_valid, cyc_addr, bank_sel_bit0, bank_sel_bit1,
		input  aux_trace_inputs_high,
		output cyc_hold, tgt_reset_n, emul_run
	);

	// Target end
	modport tgt (
		output cyc_valid, cyc_addr, bank_sel_bit0, bank_sel_bit1,
		output aux_trace_inputs_high,
		input  cyc_hold, tgt_reset_n, emul_run
	);
endinterface

`default_nettype wire

// ==== rtl/brt_fifo.sv ====
// Trace record FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none

module brt_fifo #(
	parameter int W     = brt_pkg::REC_W,
	parameter int DEPTH = brt_pkg::FIFO_DEPTH
) (
	input  wire logic         mclk,
	input  wire logic         resetn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Depth must be a power of two for pointer wrap
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("brt_fifo: DEPTH must be a power of two, at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem; // Storage words
		logic [AW-1:0]           wp;  // Write index
		logic [AW-1:0]           rp;  // Read index
		logic [AW:0]             cnt; // Words held
	} brt_fifo_s;

	brt_fifo_s q, d;
	logic push, pop;

	// ------------------------------------------------------------------
	// Handshakes
	// ------------------------------------------------------------------
	assign in_ready  = (q.cnt != (AW+1)'(DEPTH)); // Honest full
	assign out_valid = (q.cnt != '0);              // Honest empty
	assign out_data  = q.mem[q.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Next state
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp        = q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = q.rp + 1'b1;
		end
		d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
		if (!resetn) begin
			d.wp  = '0;
			d.rp  = '0;
			d.cnt = '0;
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		q <= d;
	end
endmodule

`default_nettype wire

// ==== rtl/brt_emu.sv ====
// Emulator end: reset-and-run sequencer and banked trace capture.
// Assumes the target end on brt_link_if and a host issuing pulses.
//
// Functional notes
// - Reset-and-run: emulate, trace, reset low together
// - Hold reset about 1/5 second, release
// - Trace and count cycles during reset too
// - 64-cycle write window, off in test mode
// - Low bank bits always, high via probes
// - Bank bits 2,3 feed probe bits 0,1
// - Display address: bank as fifth hex digit
// - 8K banks: lines 13-16 drive bits 0-3
// - At most sixteen banks, four-bit field
// - Connect only active lines, others unconnected
// - 32K at 4000: skip line 14
// - Many banks: high bank bits reach probes
// - 512K board, 32K reserved: fifteen banks
// - 256K board, 48K reserved: thirteen banks
`default_nettype none

module brt_emu #(
	parameter int RESET_HOLD_CYC = brt_pkg::RESET_HOLD_CYC,
	parameter int CNT_W          = brt_pkg::CNT_W,
	parameter int FIFO_DEPTH     = brt_pkg::FIFO_DEPTH
) (
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	brt_link_if.emu                         link,
	input  wire logic                       cmd_reset_go,
	input  wire logic                       cmd_stop,
	input  wire logic                       probe_bank_en,
	input  wire logic                       test_mode,
	input  wire logic                       board_512k,
	input  wire logic                       nonbanked_mapped,
	input  wire logic [2:0]                 bank_size,
	output logic                            rec_valid,
	input  wire logic                       rec_ready,
	output logic [brt_pkg::REC_W-1:0]       rec_data,
	output logic [CNT_W-1:0]                cycle_count,
	output logic                            emul_active,
	output logic                            trace_on,
	output logic                            tgt_in_reset,
	output logic                            prot_window,
	output logic [4:0]                      bank_limit,
	output logic                            bank_over
);
	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	localparam int HOLD_W = $clog2(RESET_HOLD_CYC + 1);
	localparam int PROT_W = $clog2(brt_pkg::PROT_WIN_CYC + 1);

	if (RESET_HOLD_CYC < 1) begin : g_chk_hold
		$error("brt_emu: RESET_HOLD_CYC must be at least 1");
	end
	if (CNT_W < 1) begin : g_chk_cnt
		$error("brt_emu: CNT_W must be at least 1");
	end

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1, // Monitor mode, no trace
		ST_RESET = 3'h2, // Emulating with target reset held
		ST_RUN   = 3'h4  // Emulating with reset released
	} brt_st_e;

	typedef struct packed {
		brt_st_e           st;    // Sequencer state
		logic [HOLD_W-1:0] hold;  // Reset hold cycles elapsed
		logic [PROT_W-1:0] prot;  // Write-window cycles left
		logic              rst_n; // Target reset drive
		logic [CNT_W-1:0]  cyc;   // Execution cycle counter
		logic              over;  // Bank beyond board limit seen
	} brt_emu_s;

	brt_emu_s q, d;

	logic                        tracing;   // Capture enabled
	logic                        fifo_rdy;  // Buffer has room
	logic                        cyc_take;  // Bus cycle accepted
	logic                        push;      // Record written
	logic [brt_pkg::BANK_W-1:0]  bank;      // Sampled bank number
	logic [brt_pkg::REC_W-1:0]   rec_in;    // Record to buffer

	// ------------------------------------------------------------------
	// Bank sampling and record forming
	// ------------------------------------------------------------------
	// Low bits always, high bits only when probes carry them
	always_comb begin
		bank = {2'h0, link.bank_sel_bit1, link.bank_sel_bit0};
		if (probe_bank_en) begin
			bank[3:2] = link.aux_trace_inputs_high[brt_pkg::PROBE_BANK_LSB +: 2];
		end
	end

	// Bank above the 16-bit address, fifth hex digit
	assign rec_in = {bank, link.cyc_addr};

	// Board capacity for banked emulation
	assign bank_limit = brt_pkg::brt_max_banks(board_512k, nonbanked_mapped,
		bank_size);

	// ------------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------------
	assign tracing  = (q.st != ST_IDLE);
	// Stall the target only while tracing and the buffer is full
	assign link.cyc_hold = tracing && !fifo_rdy;
	assign cyc_take = link.cyc_valid && !link.cyc_hold;
	assign push     = tracing && cyc_take;

	// ------------------------------------------------------------------
	// Trace buffer
	// ------------------------------------------------------------------
	brt_fifo #(
		.W     (brt_pkg::REC_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.resetn    (resetn),
		.in_valid  (push),
		.in_ready  (fifo_rdy),
		.in_data   (rec_in),
		.out_valid (rec_valid),
		.out_ready (rec_ready),
		.out_data  (rec_data)
	);

	// ------------------------------------------------------------------
	// Sequencer and counters
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		unique case (q.st)
			// Waiting for the host
			ST_IDLE: begin
				if (cmd_reset_go) begin
					d.st    = ST_RESET;
					d.rst_n = 1'b0;
					d.hold  = '0;
					d.cyc   = '0;
					d.over  = 1'b0;
				end
			end
			// Reset held low for the full hold time, or until a stop
			ST_RESET: begin
				d.hold = q.hold + 1'b1;
				if (cmd_stop) begin
					d.st    = ST_IDLE;
					d.rst_n = 1'b1;
				end else if (q.hold == HOLD_W'(RESET_HOLD_CYC - 1)) begin
					d.st    = ST_RUN;
					d.rst_n = 1'b1;
					d.prot  = PROT_W'(brt_pkg::PROT_WIN_CYC);
				end
			end
			// Target running its reset routine onward
			ST_RUN: begin
				if (cmd_stop) begin
					d.st   = ST_IDLE;
					d.prot = '0;
				end
			end
		endcase

		// Window counts target bus cycles after release
		if (q.st == ST_RUN && cyc_take && q.prot != '0) begin
			d.prot = q.prot - 1'b1;
		end

		// Every traced cycle counts, reset or not
		if (push) begin
			d.cyc = q.cyc + 1'b1;
		end

		// Sticky, set wins over the clear above
		if (push && ({1'b0, bank} >= bank_limit)) begin
			d.over = 1'b1;
		end

		// Synchronous reset values
		if (!resetn) begin
			d.st    = ST_IDLE;
			d.hold  = '0;
			d.prot  = '0;
			d.rst_n = 1'b1;
			d.cyc   = '0;
			d.over  = 1'b0;
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		q <= d;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign link.tgt_reset_n = q.rst_n;
	assign link.emul_run    = tracing;
	assign emul_active      = tracing;
	assign trace_on         = tracing;
	assign tgt_in_reset     = !q.rst_n;
	assign cycle_count      = q.cyc;
	assign bank_over        = q.over;
	// Window closed whenever the target runs in test mode
	assign prot_window      = (q.prot != '0) && !test_mode;
endmodule

`default_nettype wire

// ==== rtl/brt_tgt.sv ====
// Target end: bus cycle source with bank-select wiring to the link.
// Assumes the emulator end on brt_link_if and a user issuing cycles.
`default_nettype none

module brt_tgt #(
	parameter int BANK_LINES = brt_pkg::BANK_W
) (
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	brt_link_if.tgt                         link,
	input  wire logic                       req_valid,
	output logic                            req_ready,
	input  wire logic [brt_pkg::ADDR_W-1:0] req_addr,
	input  wire logic                       ext_addr_line_13,
	input  wire logic                       ext_addr_line_14,
	input  wire logic                       ext_addr_line_15,
	input  wire logic                       ext_addr_line_16,
	input  wire logic                       ext_addr_line_17,
	input  wire logic                       ext_addr_line_18,
	input  wire logic [2:0]                 bank_size,
	input  wire logic                       probe_wire_en,
	input  wire logic [1:0]                 port_probe_in,
	output logic                            in_reset,
	output logic                            emul_seen
);
	// Only one to four bank lines make sense
	if (BANK_LINES < 1 || BANK_LINES > brt_pkg::BANK_W) begin : g_chk
		$error("brt_tgt: BANK_LINES must lie in 1..4");
	end

	typedef struct packed {
		logic                       vld;   // Cycle on the link
		logic [brt_pkg::ADDR_W-1:0] addr;  // Cycle address
		logic [brt_pkg::BANK_W-1:0] bank;  // Bank bits of the cycle
		logic [1:0]                 port;  // Probe bits left for ports
	} brt_tgt_s;

	brt_tgt_s q, d;

	logic [18:13]               xa;      // Extended address lines
	logic [brt_pkg::BANK_W-1:0] bank_w;  // Bank bits from the lines

	assign xa = {ext_addr_line_18, ext_addr_line_17, ext_addr_line_16,
		ext_addr_line_15, ext_addr_line_14, ext_addr_line_13};

	// ------------------------------------------------------------------
	// Bank wiring per bank size
	// ------------------------------------------------------------------
	always_comb begin
		bank_w = xa[brt_pkg::XA_LSB_8K +: 4];
		if (bank_size == brt_pkg::BS_16K) begin
			bank_w = xa[brt_pkg::XA_LSB_16K +: 4];
		end else if (bank_size == brt_pkg::BS_32K) begin
			bank_w = xa[brt_pkg::XA_LSB_32K +: 4];
		end
		// Inputs beyond the active lines are tied to zero
		for (int i = BANK_LINES; i < brt_pkg::BANK_W; i++) begin
			bank_w[i] = 1'b0;
		end
	end

	// Offer is taken when the emulator does not hold
	assign req_ready = !q.vld || !link.cyc_hold;

	// Next state
	always_comb begin
		d = q;
		if (q.vld && !link.cyc_hold) begin
			d.vld = 1'b0;
		end
		if (req_valid && req_ready) begin
			d.vld  = 1'b1;
			d.addr = req_addr;
			d.bank = bank_w;
			d.port = port_probe_in;
		end
		if (!resetn) begin
			d = '0;
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		q <= d;
	end

	// ------------------------------------------------------------------
	// Link drive
	// ------------------------------------------------------------------
	assign link.cyc_valid     = q.vld;
	assign link.cyc_addr      = q.addr;
	assign link.bank_sel_bit0 = q.bank[0];
	assign link.bank_sel_bit1 = q.bank[1];
	// High bank bits take probe bits 0 and 1 when wired
	assign link.aux_trace_inputs_high = probe_wire_en ?
		{2'h0, q.bank[3:2]} : {2'h0, q.port};
	assign in_reset  = !link.tgt_reset_n;
	assign emul_seen = link.emul_run;
endmodule

`default_nettype wire

// ==== tb/brt_link_sva.sv ====
// Checker for the link between the emulator end and the target end.
// Assumes the signals of one brt_link_if plus the shared mclk and resetn.
`default_nettype none

module brt_link_sva #(
	parameter int HOLD = 20 // Reset hold length in mclk cycles
) (
	input wire logic                       mclk,
	input wire logic                       resetn,
	input wire logic                       cyc_valid,
	input wire logic [brt_pkg::ADDR_W-1:0] cyc_addr,
	input wire logic                       bank_sel_bit0,
	input wire logic                       bank_sel_bit1,
	input wire logic [3:0]                 aux_trace_inputs_high,
	input wire logic                       cyc_hold,
	input wire logic                       tgt_reset_n,
	input wire logic                       emul_run
);
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------------
	// Helper: cycles spent with the target reset low
	// ------------------------------------------------------------------
	logic [31:0] low_cnt_q; // Cleared whenever reset is released

	// Count low cycles, restart on release
	always_ff @(posedge mclk) begin
		if (!resetn || tgt_reset_n) begin
			low_cnt_q <= 32'h0;
		end else begin
			low_cnt_q <= low_cnt_q + 32'h1;
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb_link @(posedge mclk); endclocking
	default disable iff (!resetn);

	chk_go_together: assert property ($fell(tgt_reset_n) |-> $rose(emul_run))
		else $error("reset asserted without entering emulation");
	chk_run_starts_reset: assert property ($rose(emul_run) |-> $fell(tgt_reset_n))
		else $error("emulation entered without target reset");
	chk_reset_in_emul: assert property (!tgt_reset_n |-> emul_run)
		else $error("target reset low outside emulation");
	chk_hold_exact: assert property ($rose(tgt_reset_n) && emul_run |-> low_cnt_q == HOLD)
		else $error("reset hold length wrong");
	chk_hold_max: assert property (!tgt_reset_n |-> low_cnt_q < HOLD)
		else $error("reset held too long");
	chk_stop_releases: assert property ($fell(emul_run) |-> tgt_reset_n)
		else $error("reset left low after leaving emulation");
	chk_hold_needs_run: assert property (cyc_hold |-> emul_run)
		else $error("bus stalled while not tracing");
	chk_offer_stable: assert property (cyc_valid && cyc_hold |=> cyc_valid && $stable(cyc_addr)
		&& $stable({bank_sel_bit1, bank_sel_bit0}))
		else $error("stalled bus cycle changed");
	chk_probe_top_zero: assert property (aux_trace_inputs_high[3:2] == 2'h0)
		else $error("unused probe bits driven");

	// Main scenarios reached
	cov_release: cover property ($rose(tgt_reset_n) && emul_run);
	cov_stall: cover property (cyc_valid && cyc_hold);
	cov_leave: cover property ($fell(emul_run));
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench: emulator and target ends joined by one link.
// Assumes the design files and brt_link_sva are compiled before it.
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int HOLD = 20; // Shortened reset hold

	// ------------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------------
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        cmd_reset_go = 1'b0;
	logic        cmd_stop = 1'b0;
	logic        probe_bank_en = 1'b1;
	logic        test_mode = 1'b0;
	logic        board_512k = 1'b0;
	logic        nonbanked_mapped = 1'b0;
	logic [2:0]  bank_size = 3'h1;
	logic        rec_ready = 1'b1;
	logic        req_valid = 1'b0;
	logic [15:0] req_addr = 16'h0;
	logic [5:0]  xa = 6'h0;            // Extended lines 13 to 18
	logic        probe_wire_en = 1'b1;
	logic [1:0]  port_probe_in = 2'h0;
	logic        rec_valid, tgt_in_reset, emul_active, trace_on, prot_window;
	logic        bank_over, req_ready, in_reset, emul_seen;
	logic [19:0] rec_data;
	logic [31:0] cycle_count;
	logic [4:0]  bank_limit;
	logic [19:0] exp_q[$];             // Records still expected
	int          n_mismatch = 0;
	int          tests_run = 0;

	// Rows: bank size, extended lines, address, expected record
	logic [2:0]  r_bs[6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
	logic [5:0]  r_xa[6] = '{6'h05, 6'h3A, 6'h1E, 6'h21, 6'h33, 6'h02};
	logic [15:0] r_a[6]  = '{16'h8000, 16'h1234, 16'hFFFF, 16'h0000, 16'h4000, 16'h7FFF};
	logic [19:0] r_e[6]  = '{20'h58000, 20'hA1234, 20'hFFFFF, 20'h00000, 20'hC4000, 20'h07FFF};

	always #50 mclk = ~mclk;

	// ------------------------------------------------------------------
	// Design, link and checker
	// ------------------------------------------------------------------
	brt_link_if link ();

	brt_emu #(.RESET_HOLD_CYC(HOLD)) i_brt_emu (.mclk(mclk), .resetn(resetn), .link(link),
		.cmd_reset_go(cmd_reset_go), .cmd_stop(cmd_stop), .probe_bank_en(probe_bank_en),
		.test_mode(test_mode), .board_512k(board_512k), .nonbanked_mapped(nonbanked_mapped),
		.bank_size(bank_size), .rec_valid(rec_valid), .rec_ready(rec_ready),
		.rec_data(rec_data), .cycle_count(cycle_count), .emul_active(emul_active),
		.trace_on(trace_on), .tgt_in_reset(tgt_in_reset), .prot_window(prot_window),
		.bank_limit(bank_limit), .bank_over(bank_over));

	brt_tgt i_brt_tgt (.mclk(mclk), .resetn(resetn), .link(link), .req_valid(req_valid),
		.req_ready(req_ready), .req_addr(req_addr), .ext_addr_line_13(xa[0]),
		.ext_addr_line_14(xa[1]), .ext_addr_line_15(xa[2]), .ext_addr_line_16(xa[3]),
		.ext_addr_line_17(xa[4]), .ext_addr_line_18(xa[5]), .bank_size(bank_size),
		.probe_wire_en(probe_wire_en), .port_probe_in(port_probe_in), .in_reset(in_reset),
		.emul_seen(emul_seen));

	brt_link_sva #(.HOLD(HOLD)) i_brt_link_sva (.mclk(mclk), .resetn(resetn),
		.cyc_valid(link.cyc_valid), .cyc_addr(link.cyc_addr),
		.bank_sel_bit0(link.bank_sel_bit0), .bank_sel_bit1(link.bank_sel_bit1),
		.aux_trace_inputs_high(link.aux_trace_inputs_high), .cyc_hold(link.cyc_hold),
		.tgt_reset_n(link.tgt_reset_n), .emul_run(link.emul_run));

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic print_verdict;
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Compare one value and report a mismatch
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// A wait that ran out ends the run
	task automatic timeout;
		n_mismatch++;
		$display("Error wait expected done seen timeout");
		print_verdict();
	endtask

	// Offer one bus cycle, return at the edge that takes it
	task automatic send(input logic [2:0] bs, input logic [5:0] x, input logic [15:0] a,
		input logic [19:0] e, input bit tr);
		int n;
		@(negedge mclk);
		bank_size = bs;
		xa = x;
		req_addr = a;
		req_valid = 1'b1;
		if (tr) begin
			exp_q.push_back(e);
		end
		for (n = 0; n < 64 && req_ready !== 1'b1; n++) @(negedge mclk);
		if (n == 64) timeout();
		@(posedge mclk);
	endtask

	// Drop the request after the last send
	task automatic rel;
		@(negedge mclk);
		req_valid = 1'b0;
	endtask

	// Wait until every expected record was taken
	task automatic drain;
		int n;
		for (n = 0; n < 200 && exp_q.size() != 0; n++) @(negedge mclk);
		if (n == 200) timeout();
	endtask

	// Wait for the target reset to be released
	task automatic wait_rel;
		int n;
		for (n = 0; n < 200 && tgt_in_reset !== 1'b0; n++) @(negedge mclk);
		if (n == 200) timeout();
	endtask

	// One-cycle host command
	task automatic pulse(input bit stop);
		@(negedge mclk);
		cmd_stop = stop;
		cmd_reset_go = !stop;
		@(negedge mclk);
		cmd_stop = 1'b0;
		cmd_reset_go = 1'b0;
	endtask

	// Set board options and check the bank limit
	task automatic lim(input logic b, input logic m, input logic [2:0] s, input logic [4:0] e);
		@(negedge mclk);
		board_512k = b;
		nonbanked_mapped = m;
		bank_size = s;
		@(negedge mclk);
		check("bank_limit", 32'(e), 32'(bank_limit));
	endtask

	// ------------------------------------------------------------------
	// Record monitor: each taken record against the next expected
	// ------------------------------------------------------------------
	always @(posedge mclk) begin
		if (rec_valid === 1'b1 && rec_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("rec_extra", 32'h0, 32'h1);
			end else begin
				check("rec_data", 32'(exp_q.pop_front()), 32'(rec_data));
			end
		end
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (8) @(negedge mclk);
		check("reset_out", 32'h0, 32'({tgt_in_reset, emul_active, trace_on, rec_valid,
			prot_window, bank_over, in_reset, emul_seen, link.cyc_valid, link.cyc_hold}));
		check("reset_cyc", 32'h0, cycle_count);
		resetn = 1'b1;
		// Cycles outside emulation are not recorded
		send(3'h1, 6'h05, 16'h8000, 20'h0, 1'b0);
		rel();
		repeat (3) @(negedge mclk);
		check("idle_rec", 32'h0, 32'(rec_valid));
		// Reset-and-run, table rows traced during reset
		pulse(1'b0);
		check("go_state", 32'h1F, 32'({tgt_in_reset, emul_active, trace_on, in_reset,
			emul_seen}));
		for (int i = 0; i < 6; i++) send(r_bs[i], r_xa[i], r_a[i], r_e[i], 1'b1);
		rel();
		drain();
		check("reset_count", 32'h6, cycle_count);
		check("still_reset", 32'h1, 32'(tgt_in_reset));
		wait_rel();
		check("prot_open", 32'h1, 32'(prot_window));
		// High bank bits: none, then from the port probes
		probe_bank_en = 1'b0;
		send(3'h1, 6'h0F, 16'h0100, 20'h30100, 1'b1);
		// Options change only once the emulator has taken the cycle
		rel();
		@(negedge mclk);
		probe_bank_en = 1'b1;
		probe_wire_en = 1'b0;
		port_probe_in = 2'h2;
		send(3'h1, 6'h00, 16'h0200, 20'h80200, 1'b1);
		rel();
		@(negedge mclk);
		probe_wire_en = 1'b1;
		// Write window closes after the 64th cycle
		for (int i = 0; i < 61; i++) send(3'h1, 6'h05, 16'h8000, 20'h58000, 1'b1);
		rel();
		repeat (2) @(negedge mclk);
		check("prot_63", 32'h1, 32'(prot_window));
		send(3'h1, 6'h05, 16'h8000, 20'h58000, 1'b1);
		rel();
		repeat (2) @(negedge mclk);
		check("prot_64", 32'h0, 32'(prot_window));
		// Fill the buffer until it refuses, then drain it
		drain();
		rec_ready = 1'b0;
		for (int i = 0; i < 17; i++) send(3'h1, 6'h05, 16'h8000, 20'h58000, 1'b1);
		rel();
		repeat (6) @(negedge mclk);
		check("full_hold", 32'h3, 32'({link.cyc_hold, link.cyc_valid}));
		check("full_ready", 32'h0, 32'(req_ready));
		rec_ready = 1'b1;
		drain();
		repeat (2) @(negedge mclk);
		check("empty", 32'h0, 32'({rec_valid, link.cyc_hold}));
		// Bank limits per board and mapping
		lim(1'b0, 1'b0, 3'h4, 5'h10);
		lim(1'b1, 1'b1, 3'h4, 5'h0F);
		lim(1'b1, 1'b1, 3'h2, 5'h10);
		lim(1'b0, 1'b1, 3'h2, 5'h0D);
		check("over_clear", 32'h0, 32'(bank_over));
		send(3'h2, 6'h1A, 16'h0000, 20'hD0000, 1'b1);
		rel();
		drain();
		repeat (2) @(negedge mclk);
		check("over_set", 32'h1, 32'(bank_over));
		// Leave the run, go, second go ignored, stop mid-reset, test mode
		test_mode = 1'b1;
		pulse(1'b1);
		pulse(1'b0);
		check("over_go", 32'h0, 32'(bank_over));
		repeat (4) @(negedge mclk);
		pulse(1'b0);
		check("go_ignored", 32'h1, 32'(tgt_in_reset));
		pulse(1'b1);
		check("stopped", 32'h0, 32'({tgt_in_reset, emul_active}));
		pulse(1'b0);
		wait_rel();
		check("test_prot", 32'h2, 32'({emul_active, prot_window}));
		print_verdict();
	end
endmodule

`default_nettype wire
